// >>> rtl/dbpsc_pkg.sv
/*
 * Constants for the dual buck phase and set-point configuration block:
 * register offsets, field positions, reset values and voltage coding.
 * Assumes a 32-bit AXI4-Lite register bus and a 25 MHz clock.
 */
package dbpsc_pkg;

   // Register byte offsets, one aligned word each
   localparam logic [7:0] OFS_A_NORMAL  = 8'h00;
   localparam logic [7:0] OFS_A_STANDBY = 8'h04;
   localparam logic [7:0] OFS_A_SLEEP   = 8'h08;
   localparam logic [7:0] OFS_B_NORMAL  = 8'h10;
   localparam logic [7:0] OFS_B_STANDBY = 8'h14;
   localparam logic [7:0] OFS_B_SLEEP   = 8'h18;
   localparam logic [7:0] OFS_STATUS    = 8'h20;

   // Set-point register fields
   localparam int SETPOINT_LSB = 0;
   localparam int SETPOINT_W   = 6;
   localparam int RANGE_BIT    = 6;

   // Status register fields
   localparam int ST_ARRANGE_LSB = 0;
   localparam int ST_RANGE_A     = 2;
   localparam int ST_RANGE_B     = 3;
   localparam int ST_RSVD_A      = 4;
   localparam int ST_RSVD_B      = 5;
   localparam int ST_DUAL        = 6;
   localparam int ST_CAPTURED    = 7;

   // Reset values
   localparam logic [5:0] SETPOINT_RESET = 6'h00;
   localparam logic       RANGE_RESET    = 1'b0;

   // Phase arrangement codes
   localparam logic [1:0] ARR_SINGLE_0 = 2'h0;
   localparam logic [1:0] ARR_SINGLE_1 = 2'h1;
   localparam logic [1:0] ARR_DUAL     = 2'h2;
   localparam logic [1:0] ARR_INDEP    = 2'h3;

   // Operating modes seen on the mode pins
   typedef enum logic [1:0] {
      MODE_NORMAL  = 2'b00,
      MODE_STANDBY = 2'b01,
      MODE_SLEEP   = 2'b10,
      MODE_SPARE   = 2'b11
   } dbpsc_mode_type;

   // Voltage coding in millivolts
   localparam logic [11:0] LOW_BASE_MV   = 12'd400;
   localparam logic [11:0] LOW_STEP_MV   = 12'd25;
   localparam logic [11:0] HIGH_BASE_MV  = 12'd800;
   localparam logic [11:0] HIGH_STEP_MV  = 12'd50;
   localparam logic [5:0]  HIGH_MAX_CODE = 6'h32;

   // Strap capture delay after reset release, in cycles
   localparam logic [1:0]  CAPTURE_CYCLES = 2'h3;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> rtl/dbpsc_top.sv
/*
 * Phase arrangement, range and set-point logic for a pair of buck
 * channels, with an AXI4-Lite register slave.
 * Assumes strap and mode pins are asynchronous and static-ish; the
 * analog regulators consume the applied code and phase controls.
 */
// The address map and the AXI4-Lite slave port are this design's own decisions.
//
// Behaviour
// - Arrangement 00/01 single, 10 dual, 11 independent
// - Dual phase switches channels 180 degrees apart
// - Independent: each channel uses own registers
// - Range bit read-only, from strap only
// - Range 0: 0.40 V plus 25 mV steps
// - Range 1: 0.800 V plus 50 mV steps
// - High range codes above 1110010 reserved
// - Three set points, applied by operating mode
// - Range copied into standby and sleep registers
`timescale 1ns/1ps
module dbpsc_top #(
   parameter int CHANNELS = 2
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        reset_n,
   // Straps and mode pins
   input  wire logic [1:0]  phase_arrangement_field,
   input  wire logic [1:0]  range_strap,
   input  wire logic [1:0]  operating_mode,
   // AXI4-Lite write address
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   // AXI4-Lite write data
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // AXI4-Lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   // AXI4-Lite read data
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // Regulator controls
   output logic [13:0]      applied_code,
   output logic [23:0]      applied_millivolt,
   output logic [1:0]       reserved_code,
   output logic             dual_phase_180,
   output logic             channel_b_follows_a
);

   // Elaboration check: the logic below serves two channels only
   if (CHANNELS != 2) begin : g_bad_channels
      $error("dbpsc_top serves exactly two channels");
   end

   // Register select: 0 normal, 1 standby, 2 sleep, 3 none
   function automatic logic [1:0] kind_of(input logic [7:0] addr);
      logic [7:0] low;
      low = {4'h0, addr[3:0]};
      if (low == dbpsc_pkg::OFS_A_NORMAL)       kind_of = 2'h0;
      else if (low == dbpsc_pkg::OFS_A_STANDBY) kind_of = 2'h1;
      else if (low == dbpsc_pkg::OFS_A_SLEEP)   kind_of = 2'h2;
      else                                      kind_of = 2'h3;
   endfunction

   // Channel select: 0 A, 1 B, 2 status, 3 unmapped
   function automatic logic [1:0] chan_of(input logic [7:0] addr);
      if (addr == dbpsc_pkg::OFS_STATUS)          chan_of = 2'h2;
      else if (addr[7:4] == 4'h0 && kind_of(addr) != 2'h3) chan_of = 2'h0;
      else if (addr[7:4] == 4'h1 && kind_of(addr) != 2'h3) chan_of = 2'h1;
      else                                        chan_of = 2'h3;
   endfunction

   // Reset synchroniser
   logic       rst_meta;                 // First stage
   logic       rst_sync_n;               // Released reset
   // Pin synchronisers
   logic [5:0] pin_meta;                 // First stage
   logic [5:0] pin_sync;                 // Second stage
   // Strap capture
   logic [1:0] capture_count;            // Cycles since release
   logic       captured;                 // Straps latched
   logic [1:0] arrangement;              // Latched arrangement
   logic [1:0] range_bit;                // Latched range per channel
   // Set-point storage, [channel][kind]
   logic [5:0] setpoint [2][3];
   // Write channel holding
   logic       aw_held;                  // Address taken
   logic       w_held;                   // Data taken
   logic [7:0] aw_addr;                  // Held address
   logic [7:0] w_byte;                   // Held low data byte
   logic       w_lane;                   // Low lane strobe

   // Decoded views
   wire        shared_mode = arrangement != dbpsc_pkg::ARR_INDEP;
   wire        do_write    = aw_held && w_held && !s_axi_bvalid;
   wire [1:0]  wr_chan     = chan_of(aw_addr);
   wire [1:0]  wr_kind     = kind_of(aw_addr);
   wire [1:0]  rd_chan     = chan_of(s_axi_araddr);
   wire [1:0]  rd_kind     = kind_of(s_axi_araddr);
   wire        rd_take     = s_axi_arvalid && s_axi_arready;
   wire [1:0]  mode_pins   = pin_sync[5:4];
   wire [1:0]  mode_index  = (mode_pins == dbpsc_pkg::MODE_STANDBY) ? 2'h1 :
                             (mode_pins == dbpsc_pkg::MODE_SLEEP)   ? 2'h2 : 2'h0;

   // Handshake readiness
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   // Reset release through two flip-flops
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta   <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta   <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // Two-stage pin synchroniser
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pin_meta <= 6'h00;
         pin_sync <= 6'h00;
      end else begin
         pin_meta <= {operating_mode, range_strap, phase_arrangement_field};
         pin_sync <= pin_meta;
      end
   end

   // Strap capture once synchronisers hold real pin values
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         capture_count <= 2'h0;
         captured      <= 1'b0;
         arrangement   <= dbpsc_pkg::ARR_SINGLE_0;
         range_bit     <= {2{dbpsc_pkg::RANGE_RESET}};
      end else if (!captured) begin
         capture_count <= capture_count + 2'h1;
         if (capture_count == dbpsc_pkg::CAPTURE_CYCLES - 2'h1) begin
            captured    <= 1'b1;
            arrangement <= pin_sync[1:0];
            range_bit   <= pin_sync[3:2];
         end
      end
   end

   // Write channel: address and data taken in either order
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_byte       <= 8'h00;
         w_lane       <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= dbpsc_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane <= s_axi_wstrb[0];
         end
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_chan == 2'h3) ? dbpsc_pkg::RESP_SLVERR : dbpsc_pkg::RESP_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Set-point fields; range bit never stored from software
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < 3; k++) begin
               setpoint[c][k] <= dbpsc_pkg::SETPOINT_RESET;
            end
         end
      end else if (do_write && w_lane && wr_chan[1] == 1'b0) begin
         setpoint[wr_chan[0]][wr_kind] <= w_byte[dbpsc_pkg::SETPOINT_LSB +: dbpsc_pkg::SETPOINT_W];
      end
   end

   // Read channel: answer one cycle after address taken
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= dbpsc_pkg::RESP_OKAY;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= (rd_chan == 2'h3) ? dbpsc_pkg::RESP_SLVERR : dbpsc_pkg::RESP_OKAY;
         if (rd_chan == 2'h2) begin
            s_axi_rdata <= {24'h000000, captured, shared_mode && arrangement[1] && !arrangement[0],
                            reserved_code, range_bit, arrangement};
         end else if (rd_chan == 2'h3) begin
            s_axi_rdata <= 32'h0000_0000;
         end else begin
            // all three registers show captured range
            s_axi_rdata <= {25'h0000000, range_bit[rd_chan[0]], setpoint[rd_chan[0]][rd_kind]};
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Arrangement-driven phase controls
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         dual_phase_180      <= 1'b0;
         channel_b_follows_a <= 1'b0;
      end else begin
         // dual phase runs B 180 degrees apart
         dual_phase_180      <= arrangement == dbpsc_pkg::ARR_DUAL;
         // shared modes take control from A
         channel_b_follows_a <= shared_mode;
      end
   end

   // Per-channel applied set point and voltage
   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      wire        src       = (ch == 1 && !shared_mode) ? 1'b1 : 1'b0;
      wire        rng       = range_bit[src];
      wire [5:0]  raw       = setpoint[src][mode_index];
      // high range codes beyond the top reserved
      wire        rsvd      = rng && raw > dbpsc_pkg::HIGH_MAX_CODE;
      wire [5:0]  code      = rsvd ? dbpsc_pkg::HIGH_MAX_CODE : raw;
      wire [11:0] code_w    = {6'h00, code};
      wire [11:0] low_mv    = dbpsc_pkg::LOW_BASE_MV + 12'(code_w * dbpsc_pkg::LOW_STEP_MV);
      wire [11:0] high_mv   = dbpsc_pkg::HIGH_BASE_MV + 12'(code_w * dbpsc_pkg::HIGH_STEP_MV);

      always_ff @(posedge clock or negedge rst_sync_n) begin
         if (!rst_sync_n) begin
            applied_code[ch*7 +: 7]       <= 7'h00;
            applied_millivolt[ch*12 +: 12] <= dbpsc_pkg::LOW_BASE_MV;
            reserved_code[ch]             <= 1'b0;
         end else begin
            applied_code[ch*7 +: 7]        <= {rng, code};
            applied_millivolt[ch*12 +: 12] <= rng ? high_mv : low_mv;
            reserved_code[ch]              <= rsvd;
         end
      end
   end

endmodule // dbpsc_top

// >>> verification/dbpsc_monitor.sv
/* Checker for dbpsc_top: set-point decoding, arrangement flags, bus answers.
   Assumes it is bound to dbpsc_top and sees only its ports. */
`timescale 1ns/1ps
module dbpsc_monitor (
   // Clock and reset
   input wire logic        clock,
   input wire logic        reset_n,
   // Bus handshakes
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   // Regulator controls
   input wire logic [13:0] applied_code,
   input wire logic [23:0] applied_millivolt,
   input wire logic [1:0]  reserved_code,
   input wire logic        dual_phase_180,
   input wire logic        channel_b_follows_a
);
   // Expected millivolts from range bit and code
   wire [11:0] mv_a = applied_code[6] ? 12'h320 + 12'h032 * {6'h00, applied_code[5:0]}
                                      : 12'h190 + 12'h019 * {6'h00, applied_code[5:0]};
   wire [11:0] mv_b = applied_code[13] ? 12'h320 + 12'h032 * {6'h00, applied_code[12:7]}
                                       : 12'h190 + 12'h019 * {6'h00, applied_code[12:7]};
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   mv_a_a: assert property (applied_millivolt[11:0] == mv_a)
      else $error("channel A millivolts do not match code");
   mv_b_a: assert property (applied_millivolt[23:12] == mv_b)
      else $error("channel B millivolts do not match code");
   rsvd_clamp_a: assert property (reserved_code[0] |-> applied_code[6:0] == 7'h72)
      else $error("reserved code on A not clamped");
   rsvd_range_a: assert property (reserved_code[1] |-> applied_code[13:7] == 7'h72)
      else $error("reserved code on B outside high range");
   dual_shared_a: assert property (dual_phase_180 |-> channel_b_follows_a)
      else $error("dual phase without shared control");
   dual_hold_a: assert property (dual_phase_180 |=> dual_phase_180 [*4])
      else $error("arrangement flag changed after capture");
   read_turn_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   read_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped early");
   write_block_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && !s_axi_awready)
      else $error("write response dropped early");
   // Main scenarios reached
   cover property (dual_phase_180);
   cover property (reserved_code[1]);
   cover property (s_axi_rvalid && s_axi_rready && s_axi_rdata[6]);
endmodule // dbpsc_monitor

bind dbpsc_top dbpsc_monitor u_monitor (.clock(clock), .reset_n(reset_n),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_awready(s_axi_awready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .applied_code(applied_code),
   .applied_millivolt(applied_millivolt), .reserved_code(reserved_code),
   .dual_phase_180(dual_phase_180), .channel_b_follows_a(channel_b_follows_a));

// >>> verification/dual_buck_phase_setpoint_config_test.sv
/* Self-checking bench for dbpsc_top: straps, set points, modes, register bus.
   Assumes the design alone on a 25 MHz clock with the bench as bus master. */
`timescale 1ns/1ps
module dual_buck_phase_setpoint_config_test;
   // Design inputs
   logic        clock = 1'b0, reset_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [1:0]  phase_arrangement_field = 2'h0, range_strap = 2'h0, operating_mode = 2'h0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0]  s_axi_wstrb = 4'hf;
   // Design outputs
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        dual_phase_180, channel_b_follows_a;
   logic [1:0]  s_axi_bresp, s_axi_rresp, reserved_code;
   logic [31:0] s_axi_rdata;
   logic [13:0] applied_code;
   logic [23:0] applied_millivolt;
   int          failures = 0, checks = 0;

   dbpsc_top dut (.clock, .reset_n, .phase_arrangement_field, .range_strap, .operating_mode,
      .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
      .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .applied_code,
      .applied_millivolt, .reserved_code, .dual_phase_180, .channel_b_follows_a);

   // Free-running clock
   initial begin
      forever #20 clock = ~clock;
   end

   // Value compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Reset with straps held steady, then wait out capture
   task automatic restart(input logic [1:0] arr, input logic [1:0] rng);
      reset_n <= 1'b0;
      phase_arrangement_field <= arr;
      range_strap <= rng;
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      repeat (10) @(posedge clock);
   endtask

   // Bus write: address and data offered together
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r = 2'hx;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge clock);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            r = s_axi_bresp;
            break;
         end
      end
      s_axi_bready <= 1'b0;
      repeat (3) @(posedge clock);
      chk(r, dbpsc_pkg::RESP_OKAY);
   endtask

   // Bus read
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      d = 32'hx;
      r = 2'hx;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge clock);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            break;
         end
      end
      s_axi_rready <= 1'b0;
      @(posedge clock);
   endtask

   // Mode pins through synchronisers
   task automatic set_mode(input logic [1:0] m);
      operating_mode <= m;
      repeat (5) @(posedge clock);
   endtask

   // Every arrangement code, one reset each
   task automatic t_arrange();
      logic [31:0] d;
      logic [1:0]  r;
      for (int a = 0; a < 4; a++) begin
         restart(a[1:0], 2'h0);
         chk(dual_phase_180, a == 2);
         chk(channel_b_follows_a, a != 3);
         axi_read(dbpsc_pkg::OFS_STATUS, d, r);
         chk(d, {24'h000000, 1'b1, a == 2, 4'h0, a[1:0]});
         axi_write(dbpsc_pkg::OFS_A_NORMAL, 32'h00000010);
         if (a != 3) begin
            axi_write(dbpsc_pkg::OFS_B_NORMAL, 32'h00000010);
         end
         chk(applied_code, a == 3 ? 14'h0010 : 14'h0810);
      end
   endtask

   // Independent channels, read-only range, decoding and reserved codes
   task automatic t_independent();
      logic [31:0] d;
      logic [1:0]  r;
      restart(2'h3, 2'h2);
      axi_write(dbpsc_pkg::OFS_A_NORMAL, 32'h0000007f);
      axi_read(dbpsc_pkg::OFS_A_NORMAL, d, r);
      chk(d, 32'h0000003f);
      chk(applied_millivolt[11:0], 32'h000007b7);
      axi_write(dbpsc_pkg::OFS_B_NORMAL, 32'h00000033);
      chk(reserved_code, 2'h2);
      axi_write(dbpsc_pkg::OFS_B_NORMAL, 32'h00000032);
      chk(reserved_code, 2'h0);
      chk(applied_millivolt, 24'hce47b7);
      chk(applied_code, 14'h393f);
   endtask

   // Per-mode set points, inherited range, unmapped access
   task automatic t_modes();
      logic [31:0] d;
      logic [1:0]  r;
      axi_write(dbpsc_pkg::OFS_A_STANDBY, 32'h0000000d);
      axi_write(dbpsc_pkg::OFS_A_SLEEP, 32'h00000009);
      set_mode(2'h1);
      chk(applied_millivolt[11:0], 32'h000002d5);
      set_mode(2'h2);
      chk(applied_millivolt[11:0], 32'h00000271);
      set_mode(2'h3);
      chk(applied_millivolt[11:0], 32'h000007b7);
      set_mode(2'h0);
      axi_read(dbpsc_pkg::OFS_B_SLEEP, d, r);
      chk(d, 32'h00000040);
      axi_read(dbpsc_pkg::OFS_B_STANDBY, d, r);
      chk(d, 32'h00000040);
      axi_read(8'h30, d, r);
      chk(r, dbpsc_pkg::RESP_SLVERR);
   endtask

   // Single phase, high range: B mirrors A, reserved codes on both
   task automatic t_shared();
      restart(2'h1, 2'h1);
      axi_write(dbpsc_pkg::OFS_A_NORMAL, 32'h0000003a);
      axi_write(dbpsc_pkg::OFS_B_NORMAL, 32'h0000003a);
      chk(reserved_code, 2'h3);
      chk(applied_code, 14'h3972);
      axi_write(dbpsc_pkg::OFS_A_NORMAL, 32'h00000028);
      axi_write(dbpsc_pkg::OFS_B_NORMAL, 32'h00000028);
      chk(applied_millivolt, 24'haf0af0);
   endtask

   // Counts and verdict
   task automatic close_out();
      $display("failures %0d checks %0d", failures, checks);
      if (failures == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      t_arrange();
      t_independent();
      t_modes();
      t_shared();
      close_out();
   end

   // Watchdog, well past the expected run of about 250 cycles
   initial begin
      #(40 * 5000);
      failures++;
      close_out();
   end
endmodule // dual_buck_phase_setpoint_config_test
